// *** src/adcsq_sequencer.sv ***
// serial command port, result fifo and conversion sequencer of the converter
`timescale 1ns/1ps
module adcsq_sequencer import adcsq_pkg::*; #(
    parameter int NUM_CH = 16,
    parameter int FIFO_DEPTH = 16,
    parameter int REF_WAKE = REF_WAKE_CYC
) (
    // system
    input wire logic sys_clk,
    input wire logic reset,
    // serial port pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_out,
    output logic dout_oe,
    // convert control pins
    input wire logic start_convert_n,
    output logic eoc_n,
    // analog core
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic conv_temp,
    input wire logic conv_done,
    input wire logic [11:0] conv_data
);
    localparam int PW = $clog2(FIFO_DEPTH);

    if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
        $error("NUM_CH must be 1 to 16");
    end
    if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two");
    end
    if (REF_WAKE < 1 || REF_WAKE > 65535) begin : g_bad_wake
        $error("REF_WAKE must be 1 to 65535");
    end

    function automatic logic [3:0] f_first(input logic [7:0] b);
        return (adcsq_scan_t'(b[CONV_SCAN_LSB +: 2]) == SC_UP_TO) ? 4'h0 : b[CONV_CH_LSB +: 4];
    endfunction

    function automatic logic [3:0] f_last(input logic [7:0] b);
        return (adcsq_scan_t'(b[CONV_SCAN_LSB +: 2]) == SC_FROM) ? 4'(NUM_CH - 1) : b[CONV_CH_LSB +: 4];
    endfunction

    // pin synchronisers, order {convert, din, cs, sclk}
    logic [3:0] sync1_reg, sync2_reg, sync3_reg;
    always_ff @(posedge sys_clk) begin
        sync1_reg <= {start_convert_n, din, cs_n, sclk};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end

    logic sclk_rise, sclk_fall, cs_low, cs_fall, din_s, start_convert_n_low, start_convert_n_rise, start_convert_n_fall;
    assign sclk_rise = sync2_reg[0] & ~sync3_reg[0];
    assign sclk_fall = ~sync2_reg[0] & sync3_reg[0];
    assign cs_low = ~sync2_reg[1];
    assign cs_fall = ~sync2_reg[1] & sync3_reg[1];
    assign din_s = sync2_reg[2];
    assign start_convert_n_low = ~sync2_reg[3];
    assign start_convert_n_rise = sync2_reg[3] & ~sync3_reg[3];
    assign start_convert_n_fall = ~sync2_reg[3] & sync3_reg[3];

    // serial receive and configuration registers
    logic [2:0] in_cnt_reg, in_cnt_next;
    logic [6:0] sr_reg, sr_next;
    logic [7:0] conv_reg, conv_next, avg_reg, avg_next, setup_reg, setup_next, bip_reg, bip_next;
    adcsq_follow_t follow_reg, follow_next;
    logic byte_done, is_conv, is_rst, soft_rst, fifo_clr;
    logic [7:0] rx_byte;

    assign byte_done = cs_low & sclk_rise & (in_cnt_reg == 3'h7);
    assign rx_byte = {sr_reg, din_s};
    assign is_conv = byte_done && follow_reg == FOL_NONE && rx_byte[CONV_SEL_BIT];
    assign is_rst = byte_done && follow_reg == FOL_NONE && rx_byte[7:4] == SEL_RESET;
    assign soft_rst = is_rst && !rx_byte[RST_FIFO_BIT];
    assign fifo_clr = is_rst;

    always_comb begin
        in_cnt_next = in_cnt_reg;
        sr_next = sr_reg;
        conv_next = conv_reg;
        avg_next = avg_reg;
        setup_next = setup_reg;
        bip_next = bip_reg;
        follow_next = follow_reg;
        if (!cs_low || cs_fall) begin
            in_cnt_next = 3'h0;
        end else if (sclk_rise) begin
            in_cnt_next = in_cnt_reg + 3'h1;
            sr_next = {sr_reg[5:0], din_s};
        end
        if (byte_done) begin
            if (follow_reg == FOL_BIP) begin
                bip_next = rx_byte;
                follow_next = FOL_NONE;
            end else if (follow_reg == FOL_UNI) begin
                bip_next = bip_reg & ~rx_byte;
                follow_next = FOL_NONE;
            end else if (rx_byte[CONV_SEL_BIT]) begin
                conv_next = rx_byte;
            end else if (rx_byte[7:6] == SEL_SETUP) begin
                setup_next = rx_byte;
                if (rx_byte[SETUP_DIFF_LSB + 1]) begin
                    follow_next = rx_byte[SETUP_DIFF_LSB] ? FOL_BIP : FOL_UNI;
                end
            end else if (rx_byte[7:5] == SEL_AVG) begin
                avg_next = rx_byte;
            end
        end
        if (soft_rst) begin
            conv_next = CONV_RESET;
            avg_next = AVG_RESET;
            setup_next = SETUP_RESET;
            bip_next = BIP_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            in_cnt_reg <= 3'h0;
            sr_reg <= 7'h00;
            conv_reg <= CONV_RESET;
            avg_reg <= AVG_RESET;
            setup_reg <= SETUP_RESET;
            bip_reg <= BIP_RESET;
            follow_reg <= FOL_NONE;
        end else begin
            in_cnt_reg <= in_cnt_next;
            sr_reg <= sr_next;
            conv_reg <= conv_next;
            avg_reg <= avg_next;
            setup_reg <= setup_next;
            bip_reg <= bip_next;
            follow_reg <= follow_next;
        end
    end

    // sequencer
    adcsq_state_t state_reg, state_next;
    logic [3:0] cur_ch_reg, cur_ch_next;
    logic [5:0] conv_cnt_reg, conv_cnt_next;
    logic [4:0] rep_cnt_reg, rep_cnt_next;
    logic [16:0] acc_reg, acc_next, acc_sum;
    logic [15:0] wait_cnt_reg, wait_cnt_next;
    logic [2:0] low_cnt_reg, low_cnt_next;
    logic temp_pend_reg, temp_pend_next, issued_reg, issued_next, eoc_n_reg, eoc_n_next;
    logic start_convert_n_ok, load, go, finished, eoc_set, push_req, chan_bip;
    logic [15:0] push_data;
    logic [7:0] ld_byte;
    logic [5:0] avg_target;
    logic [4:0] rep_target;
    logic [2:0] avg_shift;
    logic [11:0] avg_val;
    adcsq_clk_t ck_mode;
    logic pin_mode;

    assign ck_mode = adcsq_clk_t'(setup_reg[SETUP_CK_LSB +: 2]);
    assign pin_mode = ~ck_mode[1];
    assign start_convert_n_ok = start_convert_n_rise && low_cnt_reg >= 3'(START_CONVERT_N_LOW_CYC);
    assign ld_byte = is_conv ? rx_byte : conv_reg;
    assign avg_target = avg_reg[AVG_EN_BIT] ? (6'h4 << avg_reg[AVG_CNT_LSB +: 2]) : 6'h1;
    assign avg_shift = avg_reg[AVG_EN_BIT] ? (3'(avg_reg[AVG_CNT_LSB +: 2]) + 3'h2) : 3'h0;
    assign rep_target = (adcsq_scan_t'(conv_reg[CONV_SCAN_LSB +: 2]) == SC_REPEAT) ?
                        {3'(avg_reg[REP_CNT_LSB +: 2]) + 3'h1, 2'h0} : 5'h1;
    assign acc_sum = acc_reg + 17'(conv_data);
    assign avg_val = 12'(acc_sum >> avg_shift);
    assign chan_bip = bip_reg[3'h7 - cur_ch_reg[3:1]];

    always_comb begin
        state_next = state_reg;
        cur_ch_next = cur_ch_reg;
        conv_cnt_next = conv_cnt_reg;
        rep_cnt_next = rep_cnt_reg;
        acc_next = acc_reg;
        wait_cnt_next = wait_cnt_reg;
        temp_pend_next = temp_pend_reg;
        issued_next = issued_reg;
        low_cnt_next = start_convert_n_low ? ((low_cnt_reg < 3'(START_CONVERT_N_LOW_CYC)) ? low_cnt_reg + 3'h1 : low_cnt_reg) : 3'h0;
        load = 1'b0;
        go = 1'b0;
        finished = 1'b0;
        eoc_set = 1'b0;
        push_req = 1'b0;
        push_data = 16'h0000;
        unique case (state_reg)
            S_IDLE: begin
                if (ck_mode == CK_PIN_SCAN && start_convert_n_ok) begin
                    load = 1'b1;
                    go = 1'b1;
                end else if (ck_mode == CK_SER_SCAN && is_conv) begin
                    load = 1'b1;
                    go = 1'b1;
                end else if (ck_mode == CK_PIN_EACH && is_conv) begin
                    load = 1'b1;
                    state_next = S_WAITP;
                end
            end
            S_WAITP: begin
                if (ck_mode != CK_PIN_EACH) begin
                    state_next = S_IDLE;
                end else if (is_conv) begin
                    load = 1'b1;
                end else if (start_convert_n_ok) begin
                    state_next = temp_pend_reg ? S_WAKE : S_CONV;
                    wait_cnt_next = 16'h0000;
                end
            end
            S_WAKE: begin
                wait_cnt_next = wait_cnt_reg + 16'h0001;
                if (wait_cnt_reg == 16'(REF_WAKE - 1)) begin
                    state_next = S_CONV;
                end
            end
            S_CONV: begin
                if (!issued_reg) begin
                    issued_next = 1'b1;
                end else if (conv_done) begin
                    issued_next = 1'b0;
                    if (temp_pend_reg) begin
                        push_req = 1'b1;
                        push_data = {RESULT_LEAD, conv_data};
                        temp_pend_next = 1'b0;
                    end else if (conv_cnt_reg + 6'h1 == avg_target) begin
                        push_req = 1'b1;
                        push_data = {RESULT_LEAD, chan_bip ? {~avg_val[11], avg_val[10:0]} : avg_val};
                        acc_next = 17'h00000;
                        conv_cnt_next = 6'h00;
                        if (rep_cnt_reg + 5'h1 == rep_target) begin
                            rep_cnt_next = 5'h00;
                            if (cur_ch_reg == f_last(conv_reg)) begin
                                finished = 1'b1;
                            end else begin
                                cur_ch_next = cur_ch_reg + 4'h1;
                            end
                        end else begin
                            rep_cnt_next = rep_cnt_reg + 5'h01;
                        end
                    end else begin
                        acc_next = acc_sum;
                        conv_cnt_next = conv_cnt_reg + 6'h01;
                    end
                    if (ck_mode == CK_PIN_EACH) begin
                        eoc_set = 1'b1;
                        state_next = S_WAITP;
                        if (finished) begin
                            cur_ch_next = f_first(conv_reg);
                        end
                    end else if (finished) begin
                        eoc_set = 1'b1;
                        state_next = S_IDLE;
                    end
                end
            end
        endcase
        if (load) begin
            cur_ch_next = f_first(ld_byte);
            temp_pend_next = ld_byte[CONV_TEMP_BIT];
            conv_cnt_next = 6'h00;
            rep_cnt_next = 5'h00;
            acc_next = 17'h00000;
            wait_cnt_next = 16'h0000;
        end
        if (go) begin
            state_next = ld_byte[CONV_TEMP_BIT] ? S_WAKE : S_CONV;
        end
        eoc_n_next = eoc_n_reg;
        if (eoc_set) begin
            eoc_n_next = 1'b0;
        end else if (cs_fall || (pin_mode && start_convert_n_fall) || soft_rst) begin
            eoc_n_next = 1'b1;
        end
        if (soft_rst) begin
            state_next = S_IDLE;
            issued_next = 1'b0;
            temp_pend_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= S_IDLE;
            cur_ch_reg <= 4'h0;
            conv_cnt_reg <= 6'h00;
            rep_cnt_reg <= 5'h00;
            acc_reg <= 17'h00000;
            wait_cnt_reg <= 16'h0000;
            low_cnt_reg <= 3'h0;
            temp_pend_reg <= 1'b0;
            issued_reg <= 1'b0;
            eoc_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cur_ch_reg <= cur_ch_next;
            conv_cnt_reg <= conv_cnt_next;
            rep_cnt_reg <= rep_cnt_next;
            acc_reg <= acc_next;
            wait_cnt_reg <= wait_cnt_next;
            low_cnt_reg <= low_cnt_next;
            temp_pend_reg <= temp_pend_next;
            issued_reg <= issued_next;
            eoc_n_reg <= eoc_n_next;
        end
    end

    // result fifo and serial output
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic [PW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next, level;
    logic [3:0] out_cnt_reg, out_cnt_next;
    logic dout_reg, dout_next, fifo_empty, fifo_full, push_ok, pop;
    logic [15:0] head, head_after;

    assign level = wr_ptr_reg - rd_ptr_reg;
    assign fifo_empty = level == '0;
    assign fifo_full = level == (PW + 1)'(FIFO_DEPTH);
    assign push_ok = push_req && !fifo_full && !fifo_clr;
    assign head = fifo_mem[rd_ptr_reg[PW-1:0]];
    assign head_after = fifo_mem[PW'(rd_ptr_reg[PW-1:0] + 1'b1)];
    assign pop = cs_low && sclk_fall && out_cnt_reg == 4'hF && !fifo_empty;

    always_comb begin
        wr_ptr_next = push_ok ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        out_cnt_next = out_cnt_reg;
        dout_next = dout_reg;
        if (cs_fall) begin
            out_cnt_next = 4'h0;
            dout_next = !fifo_empty && head[15];
        end else if (cs_low && sclk_fall) begin
            out_cnt_next = out_cnt_reg + 4'h1;
            if (out_cnt_reg == 4'hF) begin
                dout_next = level > (PW + 1)'(1) && head_after[15];
            end else begin
                dout_next = !fifo_empty && head[4'hE - out_cnt_reg];
            end
        end
        if (fifo_clr) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            out_cnt_reg <= 4'h0;
            dout_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            out_cnt_reg <= out_cnt_next;
            dout_reg <= dout_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push_ok) begin
            fifo_mem[wr_ptr_reg[PW-1:0]] <= push_data;
        end
    end

    assign dout_out = dout_reg;
    assign dout_oe = cs_low;
    assign eoc_n = eoc_n_reg;
    assign conv_start = state_reg == S_CONV && !issued_reg;
    assign conv_channel = cur_ch_reg;
    assign conv_temp = temp_pend_reg;

    // checks
    eoc_hold_low_a: assert property (@(posedge sys_clk) disable iff (reset)
        !eoc_n && !cs_fall && !(pin_mode && start_convert_n_fall) && !soft_rst |=> !eoc_n)
        else $error("end-of-conversion released without cause");
    eoc_set_wins_a: assert property (@(posedge sys_clk) disable iff (reset)
        eoc_set |=> !eoc_n)
        else $error("end-of-conversion not driven low after completion");
    pin_trigger_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg == S_IDLE && ck_mode == CK_PIN_SCAN && start_convert_n_ok && !soft_rst |=> state_reg != S_IDLE)
        else $error("pin trigger did not start a scan");
    serial_trigger_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg == S_IDLE && ck_mode == CK_SER_SCAN && is_conv |=> state_reg inside {S_WAKE, S_CONV})
        else $error("conversion write did not start a scan");
    serial_no_pin_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg == S_IDLE && ck_mode[1] && !is_conv |=> state_reg == S_IDLE)
        else $error("serial clock mode started without a conversion write");
    one_conv_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg == S_CONV && issued_reg && conv_done && !avg_reg[AVG_EN_BIT] |-> push_req)
        else $error("averaging off but no result stored");
    avg_count_a: assert property (@(posedge sys_clk) disable iff (reset)
        push_req && !temp_pend_reg |-> conv_cnt_reg == avg_target - 6'h1)
        else $error("averaged result stored after wrong conversion count");
    temp_first_a: assert property (@(posedge sys_clk) disable iff (reset)
        temp_pend_reg && !load && !soft_rst |=> temp_pend_reg || $past(push_req))
        else $error("temperature request dropped before its result was stored");
    fifo_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
        fifo_clr |=> fifo_empty && (setup_reg == SETUP_RESET || $past(rx_byte[RST_FIFO_BIT])))
        else $error("reset command misbehaved");
    dout_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
        !cs_fall && !sclk_fall |=> $stable(dout_out))
        else $error("serial output changed off the falling edge");
    ref_wake_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_reg == S_WAKE && state_next == S_CONV |-> wait_cnt_reg == 16'(REF_WAKE - 1))
        else $error("reference wake time wrong");
endmodule

// *** shared/adcsq_pkg.sv ***
// constants, field layout and enumerations for the scan and averaging sequencer
package adcsq_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int START_CONVERT_N_LOW_MIN_NS = 40;
    localparam int START_CONVERT_N_LOW_CYC = (START_CONVERT_N_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_WAKE_US = 65;
    localparam int REF_WAKE_CYC = REF_WAKE_US * 1000 / CLK_PERIOD_NS;
    // command byte selectors, compared with the top bits of a received byte
    localparam logic [1:0] SEL_SETUP = 2'h1;
    localparam logic [2:0] SEL_AVG = 3'h1;
    localparam logic [3:0] SEL_RESET = 4'h1;
    // field positions
    localparam int CONV_SEL_BIT = 7;
    localparam int CONV_CH_LSB = 3;
    localparam int CONV_SCAN_LSB = 1;
    localparam int CONV_TEMP_BIT = 0;
    localparam int AVG_EN_BIT = 4;
    localparam int AVG_CNT_LSB = 2;
    localparam int REP_CNT_LSB = 0;
    localparam int RST_FIFO_BIT = 3;
    localparam int SETUP_CK_LSB = 4;
    localparam int SETUP_DIFF_LSB = 0;
    // reset values
    localparam logic [7:0] CONV_RESET = 8'h00;
    localparam logic [7:0] AVG_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h20;
    localparam logic [7:0] BIP_RESET = 8'h00;
    // result word layout: leading zeros above a 12-bit value
    localparam logic [3:0] RESULT_LEAD = 4'h0;

    typedef enum logic [1:0] {
        CK_PIN_SCAN = 2'h0,
        CK_PIN_EACH = 2'h1,
        CK_SER_SCAN = 2'h2,
        CK_SER_EXT = 2'h3
    } adcsq_clk_t;

    typedef enum logic [1:0] {
        SC_UP_TO = 2'h0,
        SC_FROM = 2'h1,
        SC_REPEAT = 2'h2,
        SC_SINGLE = 2'h3
    } adcsq_scan_t;

    typedef enum logic [1:0] {
        FOL_NONE = 2'h0,
        FOL_UNI = 2'h1,
        FOL_BIP = 2'h2
    } adcsq_follow_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_WAKE = 2'h1,
        S_CONV = 2'h3,
        S_WAITP = 2'h2
    } adcsq_state_t;
endpackage

// *** testbench/adcsq_core_model.sv ***
// analog core stand-in: answers each request a few cycles later
`timescale 1ns/1ps
module adcsq_core_model #(parameter int DELAY = 5) (
    // core handshake
    input wire logic sys_clk,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel,
    input wire logic conv_temp,
    output logic conv_done,
    output logic [11:0] conv_data,
    // requests seen
    output int n_conv
);
    int cnt = 0;
    initial begin
        conv_done = 1'b0;
        conv_data = 12'h000;
        n_conv = 0;
    end
    // data toggles outside the answer cycle so a late read shows up
    always @(posedge sys_clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (conv_start) begin
            n_conv <= n_conv + 1;
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                conv_done <= 1'b1;
                conv_data <= conv_temp ? 12'hC3C : {conv_channel, 8'h5A};
            end
        end
    end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench: serial commands, scans, averaging, fifo and convert pin
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic din = 1'b0;
    logic start_convert_n = 1'b1;
    logic dout_out, dout_oe, eoc_n, conv_start, conv_temp, conv_done;
    logic [3:0] conv_channel;
    logic [11:0] conv_data;
    logic [15:0] word;
    logic [7:0] avg_cfg [5] = '{8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
    logic [15:0] avg_num [5] = '{16'h1, 16'h4, 16'h8, 16'h10, 16'h20};
    int n_conv, base;
    int err_count = 0;
    int checks = 0;
    always #5 sys_clk = ~sys_clk;
    adcsq_sequencer #(.REF_WAKE(20)) uut (.sys_clk(sys_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout_out(dout_out), .dout_oe(dout_oe), .start_convert_n(start_convert_n), .eoc_n(eoc_n),
        .conv_start(conv_start), .conv_channel(conv_channel), .conv_temp(conv_temp), .conv_done(conv_done),
        .conv_data(conv_data));
    adcsq_core_model core (.sys_clk(sys_clk), .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_temp(conv_temp), .conv_done(conv_done), .conv_data(conv_data), .n_conv(n_conv));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // host drives on the falling edge, takes dout at the rising edge
    task automatic spi(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din = tx[i];
            #62.5 sclk = 1'b1;
            rx[i] = dout_out;
            #62.5 sclk = 1'b0;
        end
    endtask
    task automatic xfer16(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        #100 chk({15'h0, dout_oe}, 16'h0001);
        spi(tx[15:8], rx[15:8]);
        spi(tx[7:0], rx[7:0]);
        #100 cs_n = 1'b1;
        #200;
    endtask
    task automatic wr8(input logic [7:0] tx);
        logic [7:0] rx;
        cs_n = 1'b0;
        #100 spi(tx, rx);
        #100 cs_n = 1'b1;
        #200;
    endtask
    task automatic wait_eoc;
        int n = 0;
        while (eoc_n !== 1'b0 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        chk({15'h0, eoc_n}, 16'h0000);
    endtask
    task automatic pulse(input int n);
        @(posedge sys_clk);
        #1 start_convert_n = 1'b0;
        repeat (n) @(posedge sys_clk);
        #1 start_convert_n = 1'b1;
    endtask
    task automatic rd(input logic [15:0] exp);
        xfer16(16'h0000, word);
        chk(word, exp);
        chk({15'h0, dout_oe}, 16'h0000);
    endtask
    initial begin
        #900us;
        err_count++;
        $display("BAD %0t timeout", $time);
        stop_test;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 reset = 1'b0;
        #100;
        base = n_conv;
        wr8(8'h86);
        wait_eoc;
        chk(16'(n_conv - base), 16'h1);
        rd(16'h005A);
        chk({15'h0, eoc_n}, 16'h0001);
        foreach (avg_cfg[i]) begin
            base = n_conv;
            wr8(avg_cfg[i]);
            wr8(8'h8E);
            wait_eoc;
            chk(16'(n_conv - base), avg_num[i]);
            rd(16'h015A);
        end
        for (int i = 0; i < 4; i++) begin
            base = n_conv;
            wr8(8'h20 + 8'(i));
            wr8(8'h94);
            wait_eoc;
            chk(16'(n_conv - base), 16'(4 * i + 4));
            rd(16'h025A);
            wr8(8'h1F);
            rd(16'h0000);
        end
        wr8(8'h10);
        base = n_conv;
        wr8(8'h94);
        wait_eoc;
        chk(16'(n_conv - base), 16'h4);
        wr8(8'h18);
        wr8(8'h8F);
        wait_eoc;
        rd(16'h0C3C);
        rd(16'h015A);
        xfer16(16'h6380, word);
        wr8(8'h86);
        wait_eoc;
        rd(16'h085A);
        wr8(8'h40);
        base = n_conv;
        wr8(8'h8E);
        repeat (200) @(posedge sys_clk);
        chk(16'(n_conv - base), 16'h0);
        pulse(5);
        wait_eoc;
        chk(16'(n_conv - base), 16'h1);
        @(posedge sys_clk);
        #1 start_convert_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        chk({15'h0, eoc_n}, 16'h0001);
        #1 start_convert_n = 1'b1;
        wait_eoc;
        rd(16'h095A);
        rd(16'h095A);
        wr8(8'h58);
        wr8(8'h30);
        wr8(8'h88);
        base = n_conv;
        for (int i = 0; i < 8; i++) begin
            pulse(140);
            wait_eoc;
        end
        chk(16'(n_conv - base), 16'h8);
        rd(16'h085A);
        rd(16'h095A);
        wr8(8'h81);
        base = n_conv;
        pulse(5);
        wait_eoc;
        chk(16'(n_conv - base), 16'h1);
        rd(16'h0C3C);
        stop_test;
    end
endmodule
